// ==== serial_target.sv ====
// two-wire serial target: pin sampling, start/stop detection and byte handshake
module serial_target #(
    parameter logic [6:0] DEV_ADDR = 7'h50
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOe_n,
    // user side
    input wire logic enable,
    input wire logic [7:0] rdData,
    output logic startPulse,
    output logic stopPulse,
    output logic wrPulse,
    output logic [7:0] wrData,
    output logic rdPulse
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_WRITE = 2'b10,
        ST_READ = 2'b11
    } tgt_state_e;

    // ==========================================================
    // pin synchronisers and edge detection
    logic sclMeta_reg, sclSync_reg, sclPrev_reg;
    logic sdaMeta_reg, sdaSync_reg, sdaPrev_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            {sclMeta_reg, sclSync_reg, sclPrev_reg} <= 3'h7;
            {sdaMeta_reg, sdaSync_reg, sdaPrev_reg} <= 3'h7;
        end else begin
            {sclMeta_reg, sclSync_reg, sclPrev_reg} <= {sclIn, sclMeta_reg, sclSync_reg};
            {sdaMeta_reg, sdaSync_reg, sdaPrev_reg} <= {sdaIn, sdaMeta_reg, sdaSync_reg};
        end
    end

    wire sclRise = sclSync_reg & ~sclPrev_reg;
    wire sclFall = ~sclSync_reg & sclPrev_reg;
    wire sclHigh = sclSync_reg & sclPrev_reg;
    wire startDet = sclHigh & sdaPrev_reg & ~sdaSync_reg;
    wire stopDet = sclHigh & ~sdaPrev_reg & sdaSync_reg;
    wire addrMatch = (wrData[7:1] == DEV_ADDR);

    // ==========================================================
    // bit engine
    tgt_state_e state_reg, state_next;
    logic [3:0] bitCnt_reg, bitCnt_next;
    logic [7:0] shift_next;
    logic isRead_reg, isRead_next;
    logic oe_next, wr_next, rd_next;

    always_comb begin
        state_next = state_reg;
        bitCnt_next = bitCnt_reg;
        shift_next = wrData;
        isRead_next = isRead_reg;
        oe_next = sdaOe_n;
        wr_next = 1'b0;
        rd_next = 1'b0;
        if (startDet) begin
            state_next = ST_ADDR;
            bitCnt_next = 4'h0;
            oe_next = 1'b1;
        end else if (stopDet) begin
            state_next = ST_IDLE;
            oe_next = 1'b1;
        end else if (state_reg != ST_IDLE) begin
            if (sclRise) begin
                bitCnt_next = bitCnt_reg + 4'h1;
                if (bitCnt_reg < 4'h8) begin
                    shift_next = {wrData[6:0], sdaSync_reg};
                end else if (state_reg == ST_READ && sdaSync_reg) begin
                    // master said no more bytes
                    state_next = ST_IDLE;
                end
            end else if (sclFall) begin
                if (!enable) begin
                    // deselected or not ready: let go of the bus
                    state_next = ST_IDLE;
                    oe_next = 1'b1;
                end else begin
                    case (bitCnt_reg)
                        4'h8: begin
                            if (state_reg == ST_READ) begin
                                oe_next = 1'b1;
                            end else if (state_reg == ST_ADDR && !addrMatch) begin
                                state_next = ST_IDLE;
                            end else begin
                                oe_next = 1'b0;
                                wr_next = (state_reg == ST_WRITE);
                                if (state_reg == ST_ADDR) begin
                                    isRead_next = wrData[0];
                                end
                            end
                        end
                        4'h9: begin
                            bitCnt_next = 4'h0;
                            if (state_reg == ST_READ || (state_reg == ST_ADDR && isRead_reg)) begin
                                state_next = ST_READ;
                                shift_next = rdData;
                                oe_next = rdData[7];
                                rd_next = 1'b1;
                            end else begin
                                state_next = ST_WRITE;
                                oe_next = 1'b1;
                            end
                        end
                        default: begin
                            if (state_reg == ST_READ) begin
                                oe_next = wrData[7];
                            end
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            bitCnt_reg <= 4'h0;
            wrData <= 8'h00;
            isRead_reg <= 1'b0;
            sdaOe_n <= 1'b1;
            {startPulse, stopPulse, wrPulse, rdPulse} <= 4'h0;
        end else begin
            state_reg <= state_next;
            bitCnt_reg <= bitCnt_next;
            wrData <= shift_next;
            isRead_reg <= isRead_next;
            sdaOe_n <= oe_next;
            {startPulse, stopPulse, wrPulse, rdPulse} <= {startDet, stopDet, wr_next, rd_next};
        end
    end

endmodule // serial_target

// ==== module_mgmt_status_timing.sv ====
// management status timing: constants package and the top-level control/status block
// Summary of operation
// - after power-up, hot plug or reset release, become fully functional within 2000 ms
// - reset counts only when the reset pin stays low longer than 2 us
// - start answering serial bus transfers within 2000 ms of power-up
// - within 2000 ms clear data-not-ready bit 0 of byte 2 and assert interrupt
// - after reset pin rises, reach fully functional within 2000 ms
// - low-power select high puts the module into lower power within 100 us
// - any interrupt condition drives the interrupt pin low within 200 ms
// - flags clear on read; interrupt releases within 500 us after the clear
// - receive signal loss sets its flag and asserts interrupt within 100 ms
// - transmit fault sets its flag and asserts interrupt within 200 ms
// - any other condition sets its flag and asserts interrupt within 200 ms
// - a set mask bit stops its flag driving interrupt within 100 ms
// - a cleared mask bit resumes its flag driving interrupt within 100 ms
// - module select asserted: answer serial transfers within 100 us
// - module select released: stop answering serial transfers within 100 us
// - power-down bit set enters lower power within 100 ms
// - power-down bit cleared returns to fully functional within 300 ms
// - fully functional is shown by interrupt asserted from data-not-ready clearing
// - clear-on-read deadlines start at the clock edge after the read stop
// - mask and power-down deadlines start at the clock edge after the write stop
// - answer on the serial bus at seven-bit address 1010000 (A0h)
package mgmt_timing_pkg;
    // ==========================================================
    // timing
    localparam int CLK_MHZ = 100;
    localparam int T_INIT_MS = 2000;
    localparam int INIT_CYCLES = T_INIT_MS * 1000 * CLK_MHZ;
    localparam int T_RESET_PULSE_US = 2;
    localparam logic [7:0] RESET_PULSE_CYCLES = 8'(T_RESET_PULSE_US * CLK_MHZ);
    // ==========================================================
    // serial address and byte map
    localparam logic [6:0] DEV_ADDR = 7'h50;
    localparam logic [7:0] IDENT_VALUE = 8'h5a; // arbitrary value
    localparam logic [7:0] ADDR_IDENT = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_FLAG_LOS = 8'h03;
    localparam logic [7:0] ADDR_FLAG_TXF = 8'h04;
    localparam logic [7:0] ADDR_FLAG_OTHER = 8'h05;
    localparam logic [7:0] ADDR_CTRL_PWR = 8'h5d;
    localparam logic [7:0] ADDR_MASK_LOS = 8'h64;
    localparam logic [7:0] ADDR_MASK_TXF = 8'h65;
    localparam logic [7:0] ADDR_MASK_OTHER = 8'h66;
    localparam int STATUS_DNR_BIT = 0;
    localparam int STATUS_INT_BIT = 1;
    localparam int CTRL_PDOWN_BIT = 0;
    // ==========================================================
    // synchroniser layout: {reset_n, select_n, low power, other[7:0], txf[3:0], los[3:0]}
    localparam int SYNC_W = 19;
    localparam logic [18:0] SYNC_RESET = 19'h60000;
endpackage

module module_mgmt_status_timing #(
    parameter int INIT_CYCLES = mgmt_timing_pkg::INIT_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // host control pins
    input wire logic module_reset_n,
    input wire logic module_select_n,
    input wire logic low_power_select,
    output logic interrupt_out_n,
    // two-wire serial bus, open drain
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe_n,
    // module conditions
    input wire logic [3:0] rxLosIn,
    input wire logic [3:0] txFaultIn,
    input wire logic [7:0] otherCondIn,
    // module state
    output logic lowPowerOut,
    output logic functionalOut
);

    localparam logic [27:0] INIT_LAST = 28'(INIT_CYCLES - 1);

    // ==========================================================
    // input synchronisers
    logic [mgmt_timing_pkg::SYNC_W-1:0] meta_reg, sync_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= mgmt_timing_pkg::SYNC_RESET;
            sync_reg <= mgmt_timing_pkg::SYNC_RESET;
        end else begin
            meta_reg <= {module_reset_n, module_select_n, low_power_select,
                         otherCondIn, txFaultIn, rxLosIn};
            sync_reg <= meta_reg;
        end
    end

    wire resetSync = sync_reg[18];
    wire selSync_n = sync_reg[17];
    wire lpSync = sync_reg[16];
    wire [15:0] condSync = sync_reg[15:0];

    // ==========================================================
    // reset pulse qualification
    logic resetPrev_reg;
    logic [7:0] rstLowCnt_reg, rstLowCnt_next;

    wire resetArmed = (rstLowCnt_reg == mgmt_timing_pkg::RESET_PULSE_CYCLES);
    wire inReset = resetArmed & ~resetSync;
    assign rstLowCnt_next = resetSync ? 8'h00 :
                            resetArmed ? rstLowCnt_reg : rstLowCnt_reg + 8'h01;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            resetPrev_reg <= 1'b1;
            rstLowCnt_reg <= 8'h00;
        end else begin
            resetPrev_reg <= resetSync;
            rstLowCnt_reg <= rstLowCnt_next;
        end
    end

    // ==========================================================
    // initialisation timer and data-not-ready
    logic [27:0] initCnt_reg;
    logic dataNotReady_reg, readyFlag_reg;
    logic [15:0] flag_reg, mask_reg;
    logic powerDown_reg, lowPower_reg, functional_reg, intN_reg, sdaOut_reg;
    logic [7:0] ptr_reg;
    logic ptrLoad_reg;
    wire startPulse, stopPulse, wrPulse, rdPulse;
    wire [7:0] wrData;

    wire initDone = dataNotReady_reg & (initCnt_reg == INIT_LAST);
    wire statusRead = rdPulse & (ptr_reg == mgmt_timing_pkg::ADDR_STATUS);
    // set wins over the clear-on-read of the status byte
    wire readyFlag_next = initDone | (readyFlag_reg & ~statusRead);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            initCnt_reg <= 28'h0000000;
            dataNotReady_reg <= 1'b1;
            readyFlag_reg <= 1'b0;
        end else if (inReset) begin
            initCnt_reg <= 28'h0000000;
            dataNotReady_reg <= 1'b1;
            readyFlag_reg <= 1'b0;
        end else begin
            initCnt_reg <= dataNotReady_reg ? initCnt_reg + 28'h0000001 : initCnt_reg;
            dataNotReady_reg <= dataNotReady_reg & ~initDone;
            readyFlag_reg <= readyFlag_next;
        end
    end

    // ==========================================================
    // serial target and byte pointer
    wire busEnable = ~dataNotReady_reg & ~selSync_n & ~inReset;
    wire wrHit = wrPulse & ~ptrLoad_reg;
    wire [7:0] rdData =
        (ptr_reg == mgmt_timing_pkg::ADDR_IDENT) ? mgmt_timing_pkg::IDENT_VALUE :
        (ptr_reg == mgmt_timing_pkg::ADDR_STATUS) ? {6'h00, ~intN_reg, dataNotReady_reg} :
        (ptr_reg == mgmt_timing_pkg::ADDR_FLAG_LOS) ? {4'h0, flag_reg[3:0]} :
        (ptr_reg == mgmt_timing_pkg::ADDR_FLAG_TXF) ? {4'h0, flag_reg[7:4]} :
        (ptr_reg == mgmt_timing_pkg::ADDR_FLAG_OTHER) ? flag_reg[15:8] :
        (ptr_reg == mgmt_timing_pkg::ADDR_CTRL_PWR) ? {7'h00, powerDown_reg} :
        (ptr_reg == mgmt_timing_pkg::ADDR_MASK_LOS) ? {4'h0, mask_reg[3:0]} :
        (ptr_reg == mgmt_timing_pkg::ADDR_MASK_TXF) ? {4'h0, mask_reg[7:4]} :
        (ptr_reg == mgmt_timing_pkg::ADDR_MASK_OTHER) ? mask_reg[15:8] : 8'h00;

    serial_target #(
        .DEV_ADDR(mgmt_timing_pkg::DEV_ADDR)
    ) u_target (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .sdaOe_n(sdaOe_n),
        .enable(busEnable),
        .rdData(rdData),
        .startPulse(startPulse),
        .stopPulse(stopPulse),
        .wrPulse(wrPulse),
        .wrData(wrData),
        .rdPulse(rdPulse)
    );

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_reg <= 8'h00;
            ptrLoad_reg <= 1'b0;
        end else if (startPulse) begin
            ptrLoad_reg <= 1'b1;
        end else if (wrPulse) begin
            ptrLoad_reg <= 1'b0;
            ptr_reg <= ptrLoad_reg ? wrData : ptr_reg + 8'h01;
        end else if (rdPulse) begin
            ptr_reg <= ptr_reg + 8'h01;
        end
    end

    // ==========================================================
    // flags, masks and power-down control
    wire [15:0] clrVec = {{8{rdPulse & (ptr_reg == mgmt_timing_pkg::ADDR_FLAG_OTHER)}},
                          {4{rdPulse & (ptr_reg == mgmt_timing_pkg::ADDR_FLAG_TXF)}},
                          {4{rdPulse & (ptr_reg == mgmt_timing_pkg::ADDR_FLAG_LOS)}}};
    // a condition present in the cycle of the read keeps its flag set
    wire [15:0] flag_next = (flag_reg & ~clrVec) | condSync;
    wire [15:0] mask_next = {
        (wrHit && ptr_reg == mgmt_timing_pkg::ADDR_MASK_OTHER) ? wrData : mask_reg[15:8],
        (wrHit && ptr_reg == mgmt_timing_pkg::ADDR_MASK_TXF) ? wrData[3:0] : mask_reg[7:4],
        (wrHit && ptr_reg == mgmt_timing_pkg::ADDR_MASK_LOS) ? wrData[3:0] : mask_reg[3:0]};
    wire pdWrite = wrHit & (ptr_reg == mgmt_timing_pkg::ADDR_CTRL_PWR);
    wire powerDown_next = pdWrite ? wrData[mgmt_timing_pkg::CTRL_PDOWN_BIT] : powerDown_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= 16'h0000;
            mask_reg <= 16'h0000;
            powerDown_reg <= 1'b0;
        end else if (inReset) begin
            flag_reg <= 16'h0000;
            mask_reg <= 16'h0000;
            powerDown_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            mask_reg <= mask_next;
            powerDown_reg <= powerDown_next;
        end
    end

    // ==========================================================
    // output pins and state
    wire intCause = (|(flag_reg & ~mask_reg)) | readyFlag_reg;
    wire lowPower_next = lpSync | powerDown_reg;
    wire functional_next = ~dataNotReady_reg & ~lowPower_next & ~inReset;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            intN_reg <= 1'b1;
            lowPower_reg <= 1'b0;
            functional_reg <= 1'b0;
            sdaOut_reg <= 1'b0;
        end else begin
            intN_reg <= ~intCause;
            lowPower_reg <= lowPower_next;
            functional_reg <= functional_next;
            sdaOut_reg <= 1'b0;
        end
    end

    assign interrupt_out_n = intN_reg;
    assign lowPowerOut = lowPower_reg;
    assign functionalOut = functional_reg;
    assign sdaOut = sdaOut_reg;

    // ==========================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_readyThenInt;
        readyFlag_reg ##1 !interrupt_out_n;
    endsequence

    property p_shortReset;
        $rose(dataNotReady_reg) |-> $past(resetArmed);
    endproperty
    a_shortReset: assert property (p_shortReset) else $error("init restarted without long reset");

    property p_resetRestart;
        inReset |=> dataNotReady_reg && initCnt_reg == 28'h0000000 && !functionalOut;
    endproperty
    a_resetRestart: assert property (p_resetRestart) else $error("reset did not restart init");

    property p_initTime;
        (initDone && !inReset) |=> !dataNotReady_reg;
    endproperty
    a_initTime: assert property (p_initTime) else $error("init did not finish at its count");

    property p_readyInt;
        $fell(dataNotReady_reg) |-> s_readyThenInt;
    endproperty
    a_readyInt: assert property (p_readyInt) else $error("ready did not assert interrupt");

    property p_lowPower;
        (lpSync || powerDown_reg) |=> lowPowerOut && !functionalOut;
    endproperty
    a_lowPower: assert property (p_lowPower) else $error("lower power not entered");

    property p_wake;
        ($fell(powerDown_reg) && !lpSync && !dataNotReady_reg && !inReset) |=> functionalOut;
    endproperty
    a_wake: assert property (p_wake) else $error("power-down clear did not wake");

    property p_intAssert;
        (|(condSync & ~mask_reg) && !wrHit && !inReset) |-> ##[1:2] !interrupt_out_n;
    endproperty
    a_intAssert: assert property (p_intAssert) else $error("condition did not assert interrupt");

    property p_intRelease;
        (|clrVec && ((flag_reg & ~clrVec & ~mask_reg) == 16'h0000) && !readyFlag_reg
            && condSync == 16'h0000 && !wrHit) |=> ##1 interrupt_out_n;
    endproperty
    a_intRelease: assert property (p_intRelease) else $error("interrupt not released after read");

    property p_maskInhibit;
        ((flag_reg & ~mask_reg) == 16'h0000 && !readyFlag_reg) |=> interrupt_out_n;
    endproperty
    a_maskInhibit: assert property (p_maskInhibit) else $error("masked flag drove interrupt");

    property p_deselect;
        selSync_n |-> !busEnable;
    endproperty
    a_deselect: assert property (p_deselect) else $error("bus enabled while deselected");

    property p_noAnswer;
        !busEnable |=> !$fell(sdaOe_n);
    endproperty
    a_noAnswer: assert property (p_noAnswer) else $error("ack while disabled");

    property p_riseRestart;
        (resetSync && !resetPrev_reg && $past(inReset))
            |=> dataNotReady_reg && initCnt_reg == 28'h0000001;
    endproperty
    a_riseRestart: assert property (p_riseRestart) else $error("no init restart");

    property p_stopRelease;
        stopPulse |-> sdaOe_n;
    endproperty
    a_stopRelease: assert property (p_stopRelease) else $error("held after stop");

    property p_flagSet;
        (condSync != 16'h0000 && !inReset) |=> (flag_reg & $past(condSync)) == $past(condSync);
    endproperty
    a_flagSet: assert property (p_flagSet) else $error("flag not set");

    property p_flagClear;
        (clrVec != 16'h0000 && !inReset)
            |=> (flag_reg & $past(clrVec) & ~$past(condSync)) == 16'h0000;
    endproperty
    a_flagClear: assert property (p_flagClear) else $error("read did not clear");

    property p_statusClear;
        (statusRead && !initDone && !inReset) |=> !readyFlag_reg;
    endproperty
    a_statusClear: assert property (p_statusClear) else $error("ready event kept");

endmodule // module_mgmt_status_timing

// ==== host_model.sv ====
// host controller model: two-wire serial master with pull-up on the data line
module host_model (
    // bus
    output logic scl,
    output logic sdaHost,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam realtime Q = 31.25;
    initial begin
        scl = 1'b1;
        sdaHost = 1'b1;
    end
    // ==========================================================
    // bit level: data bits change only while scl is low; start and stop move data with scl high
    task automatic xfer(input logic b, output logic r);
        #Q sdaHost = b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
    endtask
    task automatic start();
        #Q sdaHost = 1'b1;
        #Q scl = 1'b1;
        #Q sdaHost = 1'b0;
        #Q scl = 1'b0;
    endtask
    // scl stands high after the stop, outside frames
    task automatic stop();
        #Q sdaHost = 1'b0;
        #Q scl = 1'b1;
        #Q sdaHost = 1'b1;
        #Q;
    endtask
    // ==========================================================
    // byte level, msb first
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(d[i], r);
        xfer(1'b1, r);
        ack = ~r;
    endtask
    task automatic get(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        xfer(1'b1, r);
    endtask
    // ==========================================================
    // transfers: pointer then data; read uses a repeated start
    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                      output logic ok);
        logic a0, a1, a2;
        start();
        put({dev, 1'b0}, a0);
        put(ptr, a1);
        put(d, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d,
                      output logic ok);
        logic a0, a1, a2;
        start();
        put({dev, 1'b0}, a0);
        put(ptr, a1);
        start();
        put({dev, 1'b1}, a2);
        get(d);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule // host_model

// ==== tb.sv ====
// testbench for the management status timing block
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int INIT = 1000;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic module_reset_n = 1'b1;
    logic module_select_n = 1'b0;
    logic low_power_select = 1'b0;
    logic [3:0] rxLosIn = 4'h0;
    logic [3:0] txFaultIn = 4'h0;
    logic [7:0] otherCondIn = 8'h00;
    logic interrupt_out_n, sdaOut, sdaOe_n, lowPowerOut, functionalOut, scl, sdaHost, sda;
    int fails = 0;
    int tests_run = 0;
    logic [31:0] lfsr = 32'h1390;
    logic [7:0] expQ[$];
    string nameQ[$];
    logic [7:0] seenVal;
    event resultEv;
    always #5 ref_clk = ~ref_clk;
    assign sda = sdaHost & (sdaOe_n | sdaOut);
    module_mgmt_status_timing #(.INIT_CYCLES(INIT)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
        .module_reset_n(module_reset_n), .module_select_n(module_select_n),
        .low_power_select(low_power_select), .interrupt_out_n(interrupt_out_n),
        .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .rxLosIn(rxLosIn),
        .txFaultIn(txFaultIn), .otherCondIn(otherCondIn), .lowPowerOut(lowPowerOut),
        .functionalOut(functionalOut));
    host_model host_u (.scl(scl), .sdaHost(sdaHost), .sda(sda));
    // ==========================================================
    // helpers
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic post(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        expQ.push_back(exp);
        nameQ.push_back(nm);
        seenVal = seen;
        ->resultEv;
        @(negedge ref_clk);
    endtask
    always @(resultEv) check(nameQ.pop_front(), seenVal, expQ.pop_front());
    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #500000;
        fails++;
        stop_test();
    end
    // ==========================================================
    // scenarios
    initial begin
        logic ok;
        logic [7:0] d;
        logic [7:0] cond;
        settle(5);
        rst_n = 1'b1;
        host_u.rd(7'h50, mgmt_timing_pkg::ADDR_IDENT, d, ok);
        post("early ack", {7'h0, ok}, 8'h00);
        post("early functional", {7'h0, functionalOut}, 8'h00);
        settle(INIT + 20);
        post("functional", {7'h0, functionalOut}, 8'h01);
        post("ready interrupt", {7'h0, interrupt_out_n}, 8'h00);
        host_u.rd(7'h50, mgmt_timing_pkg::ADDR_STATUS, d, ok);
        post("status", d, 8'h02);
        settle(20);
        post("status release", {7'h0, interrupt_out_n}, 8'h01);
        host_u.rd(7'h51, mgmt_timing_pkg::ADDR_IDENT, d, ok);
        post("foreign ack", {7'h0, ok}, 8'h00);
        host_u.rd(7'h50, mgmt_timing_pkg::ADDR_IDENT, d, ok);
        post("ident", d, mgmt_timing_pkg::IDENT_VALUE);
        $display("test init done");
        for (int k = 0; k < 3; k++) begin
            lfsr = nextRand(lfsr);
            cond = lfsr[7:0] | 8'h01;
            if (k < 2) cond = cond & 8'h0f;
            rxLosIn = (k == 0) ? cond[3:0] : 4'h0;
            txFaultIn = (k == 1) ? cond[3:0] : 4'h0;
            otherCondIn = (k == 2) ? cond : 8'h00;
            settle(10);
            post("flag interrupt", {7'h0, interrupt_out_n}, 8'h00);
            rxLosIn = 4'h0;
            txFaultIn = 4'h0;
            otherCondIn = 8'h00;
            settle(5);
            host_u.rd(7'h50, mgmt_timing_pkg::ADDR_FLAG_LOS + 8'(k), d, ok);
            post("flag byte", d, cond);
            settle(20);
            post("flag release", {7'h0, interrupt_out_n}, 8'h01);
        end
        $display("test flags done");
        host_u.wr(7'h50, mgmt_timing_pkg::ADDR_MASK_LOS, 8'h0f, ok);
        post("mask ack", {7'h0, ok}, 8'h01);
        rxLosIn = 4'h2;
        settle(10);
        post("masked", {7'h0, interrupt_out_n}, 8'h01);
        host_u.wr(7'h50, mgmt_timing_pkg::ADDR_MASK_LOS, 8'h00, ok);
        settle(10);
        post("unmasked", {7'h0, interrupt_out_n}, 8'h00);
        rxLosIn = 4'h0;
        host_u.rd(7'h50, mgmt_timing_pkg::ADDR_FLAG_LOS, d, ok);
        post("masked flag", d, 8'h02);
        $display("test masks done");
        low_power_select = 1'b1;
        settle(10);
        post("low power pin", {6'h0, lowPowerOut, functionalOut}, 8'h02);
        low_power_select = 1'b0;
        settle(10);
        host_u.wr(7'h50, mgmt_timing_pkg::ADDR_CTRL_PWR, 8'h01, ok);
        settle(5);
        post("power down", {6'h0, lowPowerOut, functionalOut}, 8'h02);
        host_u.wr(7'h50, mgmt_timing_pkg::ADDR_CTRL_PWR, 8'h00, ok);
        settle(5);
        post("power up", {6'h0, lowPowerOut, functionalOut}, 8'h01);
        $display("test power done");
        module_select_n = 1'b1;
        settle(10);
        host_u.rd(7'h50, mgmt_timing_pkg::ADDR_IDENT, d, ok);
        post("deselected ack", {7'h0, ok}, 8'h00);
        module_select_n = 1'b0;
        settle(10);
        host_u.rd(7'h50, mgmt_timing_pkg::ADDR_IDENT, d, ok);
        post("selected ident", d, mgmt_timing_pkg::IDENT_VALUE);
        $display("test select done");
        module_reset_n = 1'b0;
        settle(100);
        module_reset_n = 1'b1;
        settle(10);
        post("short reset", {7'h0, functionalOut}, 8'h01);
        module_reset_n = 1'b0;
        settle(250);
        post("held reset", {7'h0, functionalOut}, 8'h00);
        module_reset_n = 1'b1;
        settle(INIT + 20);
        post("reset recovery", {6'h0, functionalOut, interrupt_out_n}, 8'h02);
        $display("test reset done");
        stop_test();
    end
endmodule // tb
